//--- src/sbs_pkg.sv
/*
  sbs_pkg: shared types and constants for the synchronous burst SRAM
  control block.
  Assumes: included before every other design file of the block.
*/
package sbs_pkg;

  // ------------------------------------------------------------
  // burst and lane constants
  // ------------------------------------------------------------
  localparam int          SBS_BURST_W   = 2;
  localparam int          SBS_LANE_W    = 9;
  localparam logic [1:0]  SBS_BEAT_ZERO = 2'h0;
  localparam logic [1:0]  SBS_BEAT_ONE  = 2'h1;
  // filtered pin reset, msb first: output enable off, linear order,
  // pipelined, awake, low drive (the straps' unconnected levels)
  localparam logic [4:0]  SBS_PIN_RESET = 5'h15;

  // access kinds decoded on each rising edge
  typedef enum logic [2:0] {
    SBS_OP_IDLE     = 3'b000,
    SBS_OP_DESELECT = 3'b001,
    SBS_OP_BEGIN    = 3'b010,
    SBS_OP_CONTINUE = 3'b011,
    SBS_OP_SUSPEND  = 3'b100
  } sbs_op_t;

  // synchronous control inputs sampled together
  typedef struct packed {
    logic chip_select_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_en_n;
  } sbs_ctl_t;

  // static mode straps
  typedef struct packed {
    logic linear_order_sel_n;
    logic flow_thru_sel_n;
    logic sleep_req;
    logic drive_strength_sel;
  } sbs_mode_t;

endpackage : sbs_pkg

//--- src/sbs_burst_ctr.sv
/*
  sbs_burst_ctr: two-bit burst address counter with linear or
  interleaved order.
  Assumes: load/step come from the same clock domain, decoded by the top.
*/
`timescale 1ns/1ps
`default_nettype none

module sbs_burst_ctr (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          load,
  input  wire logic                          step,
  input  wire logic [sbs_pkg::SBS_BURST_W-1:0] preset,
  input  wire logic                          interleave,
  output logic      [sbs_pkg::SBS_BURST_W-1:0] addr_lsb
);
  import sbs_pkg::*;

  logic [SBS_BURST_W-1:0] start_ff;
  logic [SBS_BURST_W-1:0] beat_ff;
  logic [SBS_BURST_W-1:0] nxt_beat;

  // ------------------------------------------------------------
  // preset and beat count
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_ff <= SBS_BEAT_ZERO;
    end else if (load) begin
      start_ff <= preset;
    end
  end

  // beat count wraps mod four so the fifth beat is the start again
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      beat_ff <= SBS_BEAT_ZERO;
    end else if (load) begin
      beat_ff <= SBS_BEAT_ZERO;
    end else if (step) begin
      beat_ff <= nxt_beat;
    end
  end

  // a continue accesses the next beat in its own cycle, so the step is
  // applied before the address is formed, not after
  always_comb begin
    if (step) begin
      nxt_beat = beat_ff + SBS_BEAT_ONE;
    end else begin
      nxt_beat = beat_ff;
    end
  end

  // address formed from start and beat: sum or xor
  always_comb begin
    if (interleave) begin
      addr_lsb = start_ff ^ nxt_beat;
    end else begin
      addr_lsb = start_ff + nxt_beat;
    end
  end

endmodule : sbs_burst_ctr

`default_nettype wire

//--- src/sbs_ctrl.sv
/*
  sbs_ctrl: control logic of a synchronous burst SRAM: command decode,
  burst counter, byte-lane writes, flow-through or pipelined reads,
  output enable and sleep.
  Assumes: controller inputs are synchronous to clk; mode straps and the
  output enable come from pins and are synchronised here, except that a
  high output enable also cuts the drivers at once.
*/
// Operation
// - burst order pin low gives linear, high gives interleaved order
// - flow select low passes data straight; high registers read data
// - sleep request low keeps device active; high enters standby
// - unconnected straps default to pipelined, high drive-select, active
// - two address lsbs feed low address and preset counter on load
// - linear order adds beat modulo four; fifth clock returns to start
// - interleaved order xors start with beat; wraps on fifth clock
// - global write low writes all lanes, lane enables ignored
// - byte write low writes lanes with low enables; none still writes
// - both writes high is a read driving every lane
// - data lanes go high impedance after a write: next cycle flow-through, two later pipelined
// - lanes c and d exist only in the wide configuration
// - chip select high with controller strobe low deselects
// - select low with processor strobe low starts read burst
// - controller strobe start: write if qualifier true, else read
// - controller strobe high, advance low continues at next address
// - same strobes with advance high suspend at current address
// - output enable high turns drivers off; low enables only active reads
`timescale 1ns/1ps
`default_nettype none

module sbs_ctrl #(
  parameter int ADDR_W = 8,
  parameter int LANES  = 4
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire sbs_pkg::sbs_ctl_t         ctl,
  input  wire logic [LANES-1:0]          lane_write_n,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic                      out_en_n,
  input  wire sbs_pkg::sbs_mode_t        mode,
  input  wire logic [LANES*sbs_pkg::SBS_LANE_W-1:0] data_in,
  output logic      [LANES*sbs_pkg::SBS_LANE_W-1:0] data_out,
  output logic      [LANES-1:0]          data_oe,
  output logic                           standby,
  output logic                           high_drive
);
  import sbs_pkg::*;

  localparam int DW = LANES * SBS_LANE_W;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // narrow part has lanes a,b; wide part adds c,d
  if (!(LANES == 2 || LANES == 4)) begin : g_bad_lanes
    $error("sbs_ctrl: LANES must be 2 or 4");
  end
  if (ADDR_W < 3) begin : g_bad_addr
    $error("sbs_ctrl: ADDR_W must be at least 3");
  end

  // ------------------------------------------------------------
  // pin synchronisers: three stages, change counts when 2 and 3 agree
  // ------------------------------------------------------------
  logic [4:0] sy1_ff;
  logic [4:0] sy2_ff;
  logic [4:0] sy3_ff;
  logic [4:0] pin_ff;
  logic [4:0] pin_raw;

  assign pin_raw = {out_en_n, mode};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sy1_ff <= SBS_PIN_RESET;
      sy2_ff <= SBS_PIN_RESET;
      sy3_ff <= SBS_PIN_RESET;
    end else begin
      sy1_ff <= pin_raw;
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end
  end

  // resets to the unconnected strap levels: pipelined, awake, low drive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_ff <= SBS_PIN_RESET;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (sy2_ff[i] == sy3_ff[i]) begin
          pin_ff[i] <= sy3_ff[i];
        end
      end
    end
  end

  logic oe_n_s;
  logic interleave;
  logic pipelined;
  logic sleep_s;
  assign oe_n_s     = pin_ff[4];
  assign interleave = pin_ff[3];
  assign pipelined  = pin_ff[2];
  assign sleep_s    = pin_ff[1];
  assign high_drive = ~pin_ff[0];
  assign standby    = sleep_s;

  // ------------------------------------------------------------
  // command decode (inputs sampled on this rising edge)
  // ------------------------------------------------------------
  sbs_op_t op;
  logic    is_write;
  logic    any_write;

  // write qualifier: global write or byte write enable
  assign any_write = !ctl.global_write_n || !ctl.byte_write_en_n;

  always_comb begin
    op       = SBS_OP_IDLE;
    is_write = 1'b0;
    if (sleep_s) begin
      op = SBS_OP_IDLE;
    end else if (!ctl.chip_select_n && !ctl.proc_addr_strobe_n) begin
      op = SBS_OP_BEGIN;
    end else if (ctl.chip_select_n && !ctl.ctrl_addr_strobe_n) begin
      op = SBS_OP_DESELECT;
    end else if (!ctl.ctrl_addr_strobe_n) begin
      op       = SBS_OP_BEGIN;
      is_write = any_write;
    end else if (!ctl.burst_step_n) begin
      op       = SBS_OP_CONTINUE;
      is_write = any_write;
    end else begin
      op       = SBS_OP_SUSPEND;
      is_write = any_write;
    end
  end

  // ------------------------------------------------------------
  // burst counter
  // ------------------------------------------------------------
  logic                   ctr_load;
  logic                   ctr_step;
  logic [SBS_BURST_W-1:0] ctr_lsb;
  logic [ADDR_W-1:0]      base_ff;

  assign ctr_load = (op == SBS_OP_BEGIN);
  assign ctr_step = (op == SBS_OP_CONTINUE);

  sbs_burst_ctr u_ctr (
    .clk        (clk),
    .resetn     (resetn),
    .load       (ctr_load),
    .step       (ctr_step),
    .preset     (addr[SBS_BURST_W-1:0]),
    .interleave (interleave),
    .addr_lsb   (ctr_lsb)
  );

  // upper address held from the last load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_ff <= '0;
    end else if (ctr_load) begin
      base_ff <= addr;
    end
  end

  // address used this cycle: external on load, else counter
  logic [ADDR_W-1:0] acc_addr;
  always_comb begin
    if (ctr_load) begin
      acc_addr = addr;
    end else begin
      acc_addr = {base_ff[ADDR_W-1:SBS_BURST_W], ctr_lsb};
    end
  end

  // ------------------------------------------------------------
  // memory array and byte-lane writes
  // ------------------------------------------------------------
  logic [DW-1:0]   mem [2**ADDR_W];
  logic [LANES-1:0] lane_we;
  logic [DW-1:0]   rd_word;
  logic            do_write;
  logic            do_read;

  assign do_write = is_write && (op != SBS_OP_IDLE) && (op != SBS_OP_DESELECT);
  assign do_read  = !is_write && (op == SBS_OP_BEGIN || op == SBS_OP_CONTINUE || op == SBS_OP_SUSPEND);

  // global write covers every lane; else per-lane enables
  assign lane_we = !ctl.global_write_n ? {LANES{1'b1}} : ~lane_write_n;

  always_ff @(posedge clk) begin
    if (do_write) begin
      for (int l = 0; l < LANES; l++) begin
        if (lane_we[l]) begin
          mem[acc_addr][l*SBS_LANE_W +: SBS_LANE_W] <= data_in[l*SBS_LANE_W +: SBS_LANE_W];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read path: flow-through stage and pipeline stage
  // ------------------------------------------------------------
  logic [DW-1:0] flow_ff;
  logic [DW-1:0] pipe_ff;
  logic          flow_act_ff;
  logic          pipe_act_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flow_ff     <= '0;
      flow_act_ff <= 1'b0;
    end else begin
      flow_act_ff <= do_read;
      if (do_read) begin
        flow_ff <= mem[acc_addr];
      end
    end
  end

  // extra stage delays data and its drive enable by one clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pipe_ff     <= '0;
      pipe_act_ff <= 1'b0;
    end else begin
      pipe_ff     <= flow_ff;
      pipe_act_ff <= flow_act_ff;
    end
  end

  logic drv_act;
  assign drv_act  = pipelined ? pipe_act_ff : flow_act_ff;
  assign data_out = pipelined ? pipe_ff : flow_ff;
  // output enable only gates drivers that a read activated; the raw pin
  // also turns them off at once, while turning on waits for the filter
  assign data_oe  = {LANES{drv_act && !oe_n_s && !out_en_n}};

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // address of the latest access, the reference for suspend and continue
  logic [ADDR_W-1:0] last_addr_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_addr_ff <= '0;
    end else if (do_read || do_write) begin
      last_addr_ff <= acc_addr;
    end
  end

  sequence s_read_flow;
    do_read && !pipelined && !sleep_s;
  endsequence

  // a pipelined read whose mode holds into the next cycle
  sequence s_read_pipe;
    (do_read && pipelined) ##1 pipelined;
  endsequence

  write_hiz_a: assert property (@(posedge clk) disable iff (!resetn)
    (do_write && !pipelined) |=> (data_oe == '0))
    else $error("lanes driven after write");

  desel_hiz_a: assert property (@(posedge clk) disable iff (!resetn)
    (op == SBS_OP_DESELECT) |=> (!flow_act_ff ##1 !pipe_act_ff))
    else $error("lanes driven after deselect");

  flow_drive_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_read_flow ##1 (!pipelined && !oe_n_s && !out_en_n)) |-> data_oe == {LANES{1'b1}})
    else $error("read lanes not driven");

  pipe_delay_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_read_pipe ##1 (pipelined && !oe_n_s && !out_en_n)) |-> data_oe == {LANES{1'b1}})
    else $error("pipelined read not delayed");

  oe_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (oe_n_s || out_en_n) |-> data_oe == '0)
    else $error("drivers on with output enable high");

  psel_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (!sleep_s && !ctl.chip_select_n && !ctl.proc_addr_strobe_n) |-> (op == SBS_OP_BEGIN && !is_write))
    else $error("processor strobe not a read");

  // linear continue: next lsbs modulo four, upper bits kept; the order
  // pin is taken as steady across a burst
  cont_step_a: assert property (@(posedge clk) disable iff (!resetn)
    (op == SBS_OP_CONTINUE && !interleave && $stable(interleave))
      |-> (acc_addr == {last_addr_ff[ADDR_W-1:SBS_BURST_W], last_addr_ff[SBS_BURST_W-1:0] + SBS_BEAT_ONE}))
    else $error("continue did not advance");

  susp_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (op == SBS_OP_SUSPEND && $stable(interleave)) |-> (acc_addr == last_addr_ff))
    else $error("suspend moved the counter");

  load_lsb_a: assert property (@(posedge clk) disable iff (!resetn)
    ctr_load |=> (u_ctr.start_ff == $past(addr[SBS_BURST_W-1:0]) && u_ctr.beat_ff == SBS_BEAT_ZERO))
    else $error("counter not preset");

  standby_a: assert property (@(posedge clk) disable iff (!resetn)
    sleep_s |-> (op == SBS_OP_IDLE && standby))
    else $error("access during standby");

endmodule : sbs_ctrl

`default_nettype wire

//--- bench/sbs_host_model.sv
/*
  sbs_host_model: behavioural memory controller driving the control block.
  Assumes: one clock; the bench calls issue() once per command cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module sbs_host_model (
  input  wire logic          clk,
  output sbs_pkg::sbs_ctl_t  ctl,
  output logic [7:0]         addr,
  output logic [3:0]         lane_write_n,
  output logic [35:0]        data_in
);
  import sbs_pkg::*;

  // idle is a deselect: select high with the controller strobe low
  initial begin
    ctl          = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    addr         = 8'h00;
    lane_write_n = 4'hf;
    data_in      = 36'h0;
  end

  // one command per cycle, changed just after the edge and held a full cycle
  task automatic issue(input sbs_ctl_t c, input logic [7:0] a, input logic [3:0] ln, input logic [35:0] d);
    @(posedge clk);
    #1;
    ctl          = c;
    addr         = a;
    lane_write_n = ln;
    // released data lines flip, so a stale value can never pass as written data
    data_in      = (!c.global_write_n || !c.byte_write_en_n) ? d : ~data_in;
  endtask : issue
endmodule : sbs_host_model

`default_nettype wire

//--- bench/test_sbs_ctrl.sv
/*
  test_sbs_ctrl: self-checking bench with a scoreboard queue of reads.
  Assumes: sbs_ctrl with ADDR_W 8 and LANES 4, host model drives controls.
*/
`timescale 1ns/1ps
`default_nettype none

module test_sbs_ctrl;
  import sbs_pkg::*;
  localparam sbs_ctl_t IDLE = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam sbs_ctl_t RDP  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam sbs_ctl_t RDC  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam sbs_ctl_t CONT = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  localparam sbs_ctl_t SUSP = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam sbs_ctl_t WRG  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  localparam sbs_ctl_t WRB  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  localparam sbs_ctl_t WCON = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  localparam sbs_ctl_t WSUS = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        out_en_n = 1'b0;
  sbs_mode_t   mode = '{1'b0, 1'b1, 1'b0, 1'b1};
  sbs_ctl_t    ctl;
  logic [7:0]  addr;
  logic [3:0]  lane_write_n, data_oe;
  logic [35:0] data_in, data_out, d;
  logic        standby, high_drive;
  logic [35:0] mem [256];
  logic [35:0] exp_q[$];
  int          cyc_q[$];
  int          cyc = 0, mismatches = 0, compares = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  sbs_host_model host_i (.clk(clk), .ctl(ctl), .addr(addr), .lane_write_n(lane_write_n), .data_in(data_in));
  sbs_ctrl #(.ADDR_W(8), .LANES(4)) sbs_ctrl_i (.clk(clk), .resetn(resetn), .ctl(ctl),
    .lane_write_n(lane_write_n), .addr(addr), .out_en_n(out_en_n), .mode(mode), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .standby(standby), .high_drive(high_drive));

  // ------------------------------------------------------------
  // checking and scoreboard
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // burst address for beat i from the current order strap
  function automatic logic [7:0] burst(input logic [7:0] a, input logic [1:0] i);
    return {a[7:2], mode.linear_order_sel_n ? (a[1:0] ^ i) : (a[1:0] + i)};
  endfunction : burst

  // expected word and the cycle it must show, flow-through one edge earlier
  task automatic note(input logic [7:0] a);
    exp_q.push_back(mem[a]);
    cyc_q.push_back(cyc + (mode.flow_thru_sel_n ? 2 : 1));
  endtask : note

  // any drive must match the oldest pending read, else it is a fault
  always @(negedge clk) begin
    if (resetn && data_oe !== 4'h0) begin
      if (exp_q.size() == 0) begin
        check("unexpected drive", 36'(data_oe), 36'h0);
      end else begin
        check("read data", data_out, exp_q.pop_front());
        check("lane enables", 36'(data_oe), 36'hf);
        check("read latency", 36'(cyc), 36'(cyc_q.pop_front()));
      end
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic rd(input logic [7:0] a, input int n, input sbs_ctl_t first);
    for (int i = 0; i < n; i++) begin
      host_i.issue(i == 0 ? first : CONT, i == 0 ? a : 8'($urandom), 4'hf, 36'h0);
      note(burst(a, 2'(i)));
    end
    host_i.issue(IDLE, 8'h0, 4'hf, 36'h0);
  endtask : rd

  task automatic done(input string name);
    settle(4);
    check("pending reads", 36'(exp_q.size()), 36'h0);
    $display("test %s done", name);
  endtask : done

  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial begin
    #200us;
    mismatches++;
    results();
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hd9dff6ea));
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    settle(6);
    check("standby", 36'(standby), 36'h0);
    check("high drive", 36'(high_drive), 36'h0);
    done("reset");
    for (int a = 0; a < 16; a++) begin
      d = {4'($urandom), $urandom};
      host_i.issue(WRG, 8'(a), 4'($urandom), d);
      mem[a] = d;
    end
    done("global write");
    for (int s = 0; s < 4; s++) rd(8'(s), 5, RDP);
    done("linear burst");
    mode.linear_order_sel_n = 1'b1;
    settle(8);
    for (int s = 0; s < 4; s++) rd(8'(4 + s), 5, RDC);
    host_i.issue(RDC, 8'h9, 4'hf, 36'h0);
    note(8'h9);
    host_i.issue(SUSP, 8'h33, 4'hf, 36'h0);
    note(8'h9);
    host_i.issue(CONT, 8'h44, 4'hf, 36'h0);
    note(burst(8'h9, 2'h1));
    host_i.issue(IDLE, 8'h0, 4'hf, 36'h0);
    done("interleaved and suspend");
    // each word is filled first so the lanes left alone hold known data
    for (int ln = 0; ln < 16; ln++) begin
      d = {4'($urandom), $urandom};
      host_i.issue(WRG, 8'(32 + ln), 4'hf, d);
      mem[32 + ln] = d;
      d = {4'($urandom), $urandom};
      host_i.issue(WRB, 8'(32 + ln), 4'(ln), d);
      for (int k = 0; k < 4; k++) if (!ln[k]) mem[32 + ln][k*9 +: 9] = d[k*9 +: 9];
      rd(8'(32 + ln), 1, RDP);
    end
    done("byte write");
    // write burst: begin, continue, suspend on the same beat, continue
    for (int i = 0; i < 4; i++) begin
      d = {4'($urandom), $urandom};
      host_i.issue(i == 0 ? WRG : (i == 2 ? WSUS : WCON),
                   i == 0 ? 8'h42 : 8'($urandom), 4'($urandom), d);
      mem[burst(8'h42, 2'(i < 2 ? i : i - 1))] = d;
    end
    rd(8'h42, 3, RDC);
    done("write burst");
    mode.flow_thru_sel_n = 1'b0;
    settle(8);
    rd(8'h3, 4, RDP);
    done("flow through");
    out_en_n = 1'b1;
    settle(6);
    host_i.issue(RDP, 8'h1, 4'hf, 36'h0);
    host_i.issue(IDLE, 8'h0, 4'hf, 36'h0);
    settle(4);
    out_en_n = 1'b0;
    mode.sleep_req = 1'b1;
    settle(8);
    check("standby", 36'(standby), 36'h1);
    host_i.issue(WRG, 8'h0, 4'h0, 36'h0);
    host_i.issue(RDP, 8'h0, 4'hf, 36'h0);
    host_i.issue(IDLE, 8'h0, 4'hf, 36'h0);
    mode.sleep_req = 1'b0;
    mode.drive_strength_sel = 1'b0;
    settle(8);
    check("standby", 36'(standby), 36'h0);
    check("high drive", 36'(high_drive), 36'h1);
    rd(8'h0, 1, RDP);
    done("refusals");
    results();
  end
endmodule : test_sbs_ctrl

`default_nettype wire
